// ---- src/stp_pkg.sv ----
// Shared constants and types for the speech test serial port
package stp_pkg;
  localparam int unsigned STP_CLK_HZ = 20_000_000;
  localparam int unsigned STP_BIT_HZ = 104_000;
  localparam int unsigned STP_SAMPLE_HZ = 8_000;
  localparam int unsigned STP_WORD_W = 13;
  // Bit period rounded down so the rate never falls below nominal
  localparam int unsigned STP_BIT_CYC = STP_CLK_HZ / STP_BIT_HZ;
  localparam int unsigned STP_HALF_CYC = STP_BIT_CYC / 2;
  localparam int unsigned STP_SAMPLE_CYC = STP_CLK_HZ / STP_SAMPLE_HZ;
  localparam logic [7:0] STP_PH_RISE = 8'(STP_HALF_CYC - 1);
  localparam logic [7:0] STP_PH_FALL = 8'(STP_BIT_CYC - 1);
  localparam logic [11:0] STP_TICK_LAST = 12'(STP_SAMPLE_CYC - 1);
  localparam logic [3:0] STP_LAST_BIT = 4'(STP_WORD_W - 1);

  typedef enum logic [1:0] {
    STP_NORMAL = 2'b00,
    STP_DL_TEST = 2'b01,
    STP_UL_TEST = 2'b10,
    STP_AC_TEST = 2'b11
  } stp_mode_t;

  typedef enum logic [1:0] {
    STP_ST_IDLE = 2'b00,
    STP_ST_WAIT = 2'b01,
    STP_ST_RUN = 2'b10,
    STP_ST_SHIFT = 2'b11
  } stp_state_t;
endpackage

// ---- src/stp_sync.sv ----
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module stp_sync #(
  parameter int unsigned W = 1,
  // Level each flop wakes up at, matching the idle level of its pin
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_q <= RST_VAL;
      q_o <= RST_VAL;
    end
    else
    begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule

// ---- src/stp_top.sv ----
// Speech test serial port, mobile station end
// How it works
// - The tester reset pin counts as asserted while low, released when high.
// - Each sample is a 13-bit two's complement word shifted MSB first.
// - Data out changes on the bit clock fall; data in is taken on the rise.
// - The bit clock stays high whenever no word is being shifted.
// - Lines 1 and 2 select normal, downlink, uplink or acoustic test.
// - After release the clock runs only for transfers, near 104 kHz, 50 %.
// - Uplink test fetches the first bit at the first frame after release.
// - Downlink test starts once a received block completes after release.
// - Reset release in any test mode pulses the transcoder reset.
// - The mode may instead come from a layer 3 test routing command.
// - Samples run at 8000 per second on one data line per direction.
// - This end drives the bit clock and downlink data; the tester drives the rest.
// - One selection method is built in, chosen by a parameter.
`timescale 1ns/1ps
module stp_top
  import stp_pkg::*;
#(
  parameter bit USE_L3 = 1'b0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Tester pins
  input wire logic test_ctl1_i,
  input wire logic test_ctl2_i,
  input wire logic tester_rst_n_i,
  input wire logic ul_data_i,
  output logic dl_data_o,
  output logic bit_clk_o,
  // Layer 3 mode command
  input wire logic l3_mode_valid_i,
  input wire logic [1:0] l3_mode_i,
  // Frame timing from the radio side
  input wire logic ul_frame_i,
  input wire logic dl_block_done_i,
  // Speech path
  input wire logic dl_sample_valid_i,
  input wire logic [STP_WORD_W-1:0] dl_sample_i,
  output logic ul_sample_valid_o,
  output logic [STP_WORD_W-1:0] ul_sample_o,
  output logic transcoder_rst_o,
  output logic [1:0] mode_o
);
  logic rst_meta_q;
  logic rst_n_q;
  logic [3:0] pins_s;
  logic ctl1_s;
  logic ctl2_s;
  logic trst_n_s;
  logic ul_data_s;
  logic trst_n_prev_q;
  stp_mode_t mode_q;
  stp_state_t state_q;
  logic [7:0] ph_q;
  logic [3:0] bit_q;
  logic [11:0] tick_q;
  logic [STP_WORD_W-1:0] tx_q;
  logic [STP_WORD_W-1:0] rx_q;
  logic [STP_WORD_W-1:0] dl_hold_q;
  logic clk_q;
  logic dout_q;
  logic uvalid_q;
  logic [STP_WORD_W-1:0] usample_q;
  logic xrst_q;

  // Local reset: asserted at once, released after two clocks
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // Tester reset pin idles high; waking its copy released avoids a false
  // release edge, and so a stray transcoder reset, after local reset
  stp_sync #(.W(4), .RST_VAL(4'h2)) u_pin_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_q),
    .d_i({test_ctl1_i, test_ctl2_i, tester_rst_n_i, ul_data_i}),
    .q_o(pins_s)
  );

  assign ctl1_s = pins_s[3];
  assign ctl2_s = pins_s[2];
  assign trst_n_s = pins_s[1];
  assign ul_data_s = pins_s[0];

  wire logic release_w = trst_n_s && !trst_n_prev_q;
  wire logic active_w = (mode_q != STP_NORMAL);
  wire logic ph_rise_w = (ph_q == STP_PH_RISE);
  wire logic ph_fall_w = (ph_q == STP_PH_FALL);
  wire logic last_bit_w = (bit_q == STP_LAST_BIT);
  wire logic tick_w = (tick_q == STP_TICK_LAST);
  // Start trigger depends on which path is under test
  wire logic start_ok_w = (mode_q == STP_UL_TEST) ? ul_frame_i :
    (mode_q == STP_DL_TEST) ? dl_block_done_i : 1'b1;
  wire logic start_w = (state_q == STP_ST_WAIT && start_ok_w)
    || (state_q == STP_ST_RUN && tick_w);
  // Lines or command; only one method is honoured per build
  wire logic [1:0] mode_sel_w = USE_L3 ? l3_mode_i
    : {ctl1_s, ctl2_s};
  wire logic mode_load_w = USE_L3 ? l3_mode_valid_i : 1'b1;

  always_ff @(posedge clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      mode_q <= STP_NORMAL;
      trst_n_prev_q <= 1'b1;
      xrst_q <= 1'b0;
      dl_hold_q <= '0;
    end
    else
    begin
      trst_n_prev_q <= trst_n_s;
      if (mode_load_w)
        mode_q <= stp_mode_t'(mode_sel_w);
      xrst_q <= release_w && active_w;
      if (dl_sample_valid_i)
        dl_hold_q <= dl_sample_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      state_q <= STP_ST_IDLE;
      ph_q <= '0;
      bit_q <= '0;
      tick_q <= '0;
      tx_q <= '0;
      rx_q <= '0;
      clk_q <= 1'b1;
      dout_q <= 1'b0;
      uvalid_q <= 1'b0;
      usample_q <= '0;
    end
    else
    begin
      uvalid_q <= 1'b0;
      tick_q <= (start_w || tick_w) ? '0 : tick_q + 12'h001;
      // Pin reset or normal mode stops the shifter while the sample tick keeps counting, clock parked high
      if (!trst_n_s || !active_w)
      begin
        state_q <= STP_ST_IDLE;
        clk_q <= 1'b1;
        dout_q <= 1'b0;
      end
      else if (start_w)
      begin
        state_q <= STP_ST_SHIFT;
        clk_q <= 1'b0;
        dout_q <= dl_hold_q[STP_WORD_W-1];
        tx_q <= {dl_hold_q[STP_WORD_W-2:0], 1'b0};
        ph_q <= '0;
        bit_q <= '0;
      end
      else
      begin
        case (state_q)
          STP_ST_IDLE:
          begin
            if (release_w)
              state_q <= STP_ST_WAIT;
          end
          STP_ST_SHIFT:
          begin
            ph_q <= ph_q + 8'h01;
            if (ph_rise_w)
            begin
              clk_q <= 1'b1;
              rx_q <= {rx_q[STP_WORD_W-2:0], ul_data_s};
            end
            else if (ph_fall_w && last_bit_w)
            begin
              state_q <= STP_ST_RUN;
              usample_q <= rx_q;
              uvalid_q <= 1'b1;
            end
            else if (ph_fall_w)
            begin
              clk_q <= 1'b0;
              dout_q <= tx_q[STP_WORD_W-1];
              tx_q <= {tx_q[STP_WORD_W-2:0], 1'b0};
              ph_q <= '0;
              bit_q <= bit_q + 4'h1;
            end
          end
          default:
          begin
            state_q <= state_q;
          end
        endcase
      end
    end
  end

  assign bit_clk_o = clk_q;
  assign dl_data_o = dout_q;
  assign ul_sample_o = usample_q;
  assign ul_sample_valid_o = uvalid_q;
  assign transcoder_rst_o = xrst_q;
  assign mode_o = mode_q;

  a_idle_clk_high: assert property (@(posedge clk_i)
    disable iff (!rst_n_q) (state_q != STP_ST_SHIFT) |-> bit_clk_o)
    else $error("bit clock low outside a transfer");
  a_normal_quiet: assert property (@(posedge clk_i)
    disable iff (!rst_n_q)
    (mode_q == STP_NORMAL) |=> bit_clk_o && !ul_sample_valid_o)
    else $error("activity in normal mode");
  // Judged from the synced pin itself, not from the edge detector
  a_xcvr_reset: assert property (@(posedge clk_i)
    disable iff (!rst_n_q)
    ($rose(trst_n_s) && mode_q != STP_NORMAL) |=> transcoder_rst_o)
    else $error("transcoder reset missing after release");
  a_xcvr_only_test: assert property (@(posedge clk_i)
    disable iff (!rst_n_q)
    transcoder_rst_o |-> $past(trst_n_s) && !$past(trst_n_s, 2)
      && $past(mode_q) != STP_NORMAL)
    else $error("transcoder reset without release");
  a_mode_lines: assert property (@(posedge clk_i)
    disable iff (!rst_n_q)
    !USE_L3 |=> mode_o == $past({ctl1_s, ctl2_s}))
    else $error("mode does not follow control lines");
  a_low_half: assert property (@(posedge clk_i)
    disable iff (!rst_n_q)
    ($fell(bit_clk_o) && trst_n_s && active_w) |-> ##96 $rose(bit_clk_o)
      || !trst_n_s || !active_w)
    else $error("bit clock low phase wrong");
  a_data_on_fall: assert property (@(posedge clk_i)
    disable iff (!rst_n_q)
    ($changed(dl_data_o) && active_w && trst_n_s) |-> $fell(bit_clk_o))
    else $error("output data changed off the falling edge");
  a_msb_first: assert property (@(posedge clk_i)
    disable iff (!rst_n_q)
    (start_w && trst_n_s && active_w)
      |=> dl_data_o == $past(dl_hold_q[STP_WORD_W-1]))
    else $error("first bit is not the sign bit");
  a_ul_wait_frame: assert property (@(posedge clk_i)
    disable iff (!rst_n_q)
    (state_q == STP_ST_WAIT && mode_q == STP_UL_TEST && !ul_frame_i)
      |=> state_q != STP_ST_SHIFT)
    else $error("uplink transfer before block frame");
  a_word_done: assert property (@(posedge clk_i)
    disable iff (!rst_n_q)
    ul_sample_valid_o |-> $past(state_q) == STP_ST_SHIFT
      && $past(bit_q) == STP_LAST_BIT)
    else $error("sample delivered before 13 bits");
endmodule

// ---- dv/stp_tester_model.sv ----
// Behavioural tester at the far end of the speech test port
`timescale 1ns/1ps
module stp_tester_model (
  // Link pins
  input wire logic bit_clk_i,
  input wire logic dl_data_i,
  input wire logic rst_n_i,
  output logic ul_data_o,
  // Test words
  input wire logic [12:0] tx_word_i,
  output logic [12:0] rx_word_o
);
  int bit_n = 0;
  initial ul_data_o = 1'b0;
  initial rx_word_o = 13'h0000;
  always @(negedge rst_n_i) bit_n = 0;
  // One line per direction, MSB first
  always @(negedge bit_clk_i) ul_data_o = tx_word_i[12 - bit_n];
  always @(posedge bit_clk_i)
  begin
    rx_word_o = {rx_word_o[11:0], dl_data_i};
    bit_n = (bit_n == 12) ? 0 : bit_n + 1;
    // Hold time over: show a changed level, never a stale bit
    #1000 ul_data_o = ~ul_data_o;
  end
endmodule

// ---- dv/stp_top_bench.sv ----
// Self-checking bench for the speech test serial port
`timescale 1ns/1ps
module stp_top_bench;
  logic clk_i = 1'b0, arst_n_i = 1'b0, test_ctl1_i = 1'b0;
  logic test_ctl2_i = 1'b0, tester_rst_n_i = 1'b1, ul_data_i;
  logic ul_frame_i = 1'b0, dl_block_done_i = 1'b0;
  logic dl_sample_valid_i = 1'b0, dl_data_o, bit_clk_o;
  logic [12:0] dl_sample_i = 13'h0000, ul_sample_o, tx_word, rx_word;
  logic ul_sample_valid_o, transcoder_rst_o;
  logic [1:0] mode_o, l3_mode = 2'b00, l3_mode_o;
  logic l3_valid = 1'b0;
  int error_cnt = 0, n_compared = 0;
  bit hit;
  always #25 clk_i = ~clk_i;
  stp_top dut_u (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .test_ctl1_i(test_ctl1_i), .test_ctl2_i(test_ctl2_i),
    .tester_rst_n_i(tester_rst_n_i), .ul_data_i(ul_data_i),
    .dl_data_o(dl_data_o), .bit_clk_o(bit_clk_o),
    .l3_mode_valid_i(1'b0), .l3_mode_i(2'b00),
    .ul_frame_i(ul_frame_i), .dl_block_done_i(dl_block_done_i),
    .dl_sample_valid_i(dl_sample_valid_i), .dl_sample_i(dl_sample_i),
    .ul_sample_valid_o(ul_sample_valid_o), .ul_sample_o(ul_sample_o),
    .transcoder_rst_o(transcoder_rst_o), .mode_o(mode_o));
  stp_tester_model tester_u (.bit_clk_i(bit_clk_o), .dl_data_i(dl_data_o),
    .rst_n_i(tester_rst_n_i), .ul_data_o(ul_data_i),
    .tx_word_i(tx_word), .rx_word_o(rx_word));
  // Second build that takes its mode from the layer 3 command
  stp_top #(.USE_L3(1'b1)) dut_l3_u (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .test_ctl1_i(test_ctl1_i), .test_ctl2_i(test_ctl2_i),
    .tester_rst_n_i(tester_rst_n_i), .ul_data_i(ul_data_i),
    .dl_data_o(), .bit_clk_o(),
    .l3_mode_valid_i(l3_valid), .l3_mode_i(l3_mode),
    .ul_frame_i(ul_frame_i), .dl_block_done_i(dl_block_done_i),
    .dl_sample_valid_i(dl_sample_valid_i), .dl_sample_i(dl_sample_i),
    .ul_sample_valid_o(), .ul_sample_o(),
    .transcoder_rst_o(), .mode_o(l3_mode_o));
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [12:0] e, g);
    n_compared++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Absence of a pulse is legal only when must is clear
  task automatic wait_sig(input int s, n, input bit must);
    hit = 1'b0;
    for (int i = 0; i < n && !hit; i++)
    begin
      @(negedge clk_i);
      hit = (s == 0) ? transcoder_rst_o === 1'b1 : ul_sample_valid_o === 1'b1;
    end
    if (must && !hit)
    begin
      chk("wait_done", 13'h0001, 13'h0000);
      final_report();
    end
  endtask
  task automatic idle(input int n);
    int lows = 0;
    repeat (n) @(negedge clk_i) lows += (bit_clk_o !== 1'b1);
    chk("bit_clk_idle", 13'h0000, 13'(lows));
  endtask
  // Tester reset pulse with a mode on the lines; short on purpose
  task automatic start(input logic [1:0] m, input logic [12:0] tx, dl);
    @(negedge clk_i);
    {test_ctl1_i, test_ctl2_i} = m;
    tester_rst_n_i = 1'b0;
    tx_word = tx;
    dl_sample_i = dl;
    dl_sample_valid_i = 1'b1;
    @(negedge clk_i);
    dl_sample_valid_i = 1'b0;
    repeat (10) @(negedge clk_i);
    tester_rst_n_i = 1'b1;
    wait_sig(0, 20, m != 2'b00);
    chk("transcoder_rst", 13'(m != 2'b00), 13'(hit));
    chk("mode", 13'(m), 13'(mode_o));
  endtask
  task automatic word(input logic [12:0] tx, dl);
    wait_sig(1, 3000, 1'b1);
    chk("ul_sample", tx, ul_sample_o);
    chk("dl_word", dl, rx_word);
  endtask
  // Command loads only on its strobe; the lines stay at normal meanwhile
  task automatic scen_l3();
    @(negedge clk_i) {l3_valid, l3_mode} = 3'b101;
    @(negedge clk_i) {l3_valid, l3_mode} = 3'b010;
    repeat (3) @(negedge clk_i);
    chk("l3_mode", 13'h0001, 13'(l3_mode_o));
    chk("line_mode", 13'h0000, 13'(mode_o));
  endtask
  task automatic scen_normal();
    start(2'b00, 13'h0AAA, 13'h1555);
    idle(300);
  endtask
  task automatic scen_acoustic();
    int n = 0;
    start(2'b11, 13'h1000, 13'h0FFF);
    while (bit_clk_o !== 1'b0 && n < 300) @(negedge clk_i) n++;
    n = 0;
    while (bit_clk_o === 1'b0 && n < 300) @(negedge clk_i) n++;
    chk("low_phase", 13'h0060, 13'(n));
    n = 0;
    while (bit_clk_o === 1'b1 && n < 300) @(negedge clk_i) n++;
    chk("high_phase", 13'h0060, 13'(n));
    word(13'h1000, 13'h0FFF);
    // Step off the pulse just seen before timing the next one
    n = 0;
    @(negedge clk_i) n++;
    while (ul_sample_valid_o !== 1'b1 && n < 3000) @(negedge clk_i) n++;
    chk("word_gap", 13'h09C4, 13'(n));
  endtask
  task automatic scen_uplink();
    start(2'b10, 13'h0FFF, 13'h1000);
    idle(200);
    @(negedge clk_i) ul_frame_i = 1'b1;
    @(negedge clk_i) ul_frame_i = 1'b0;
    word(13'h0FFF, 13'h1000);
  endtask
  task automatic scen_downlink();
    start(2'b01, 13'h1555, 13'h0AAA);
    idle(200);
    @(negedge clk_i) dl_block_done_i = 1'b1;
    @(negedge clk_i) dl_block_done_i = 1'b0;
    word(13'h1555, 13'h0AAA);
  endtask
  task automatic scen_abort();
    @(negedge clk_i) {test_ctl1_i, test_ctl2_i} = 2'b00;
    repeat (10) @(negedge clk_i);
    idle(300);
  endtask
  initial
  begin
    repeat (10) @(negedge clk_i);
    arst_n_i = 1'b1;
    repeat (5) @(negedge clk_i);
    scen_l3();
    scen_normal();
    scen_acoustic();
    scen_abort();
    scen_uplink();
    scen_downlink();
    scen_abort();
    final_report();
  end
endmodule
